// ==== tsw_cfg.svh ====
// register map, field positions, reset values and timing counts of the sensor result block
// assumes inclusion by bare name from every design file that decodes registers
// Overview of operation
// - enable busy raised during enable synchronisation
// - soft reset busy raised during its synchronisation
// - result is signed 24-bit, read-only, resets zero
// - lower threshold writable unless enabled or protected
// - upper threshold writable unless enabled or protected
// - gain survives soft reset, locked when enabled
// - gain sets sensor periods per measurement
// - window flag one cycle after match, cleared
// - overflow sets its flag, not result ready
// - result ready cleared by one or read
`ifndef TSW_CFG_SVH
`define TSW_CFG_SVH
`define TSW_OFS_CTRL 8'h00
`define TSW_OFS_FLAGS 8'h04
`define TSW_OFS_SYNC 8'h08
`define TSW_OFS_RESULT 8'h0C
`define TSW_OFS_WINLO 8'h10
`define TSW_OFS_WINHI 8'h14
`define TSW_OFS_GAIN 8'h18
`define TSW_CTRL_SRST 0
`define TSW_CTRL_EN 1
`define TSW_CTRL_WINEN 2
`define TSW_FLG_RDY 0
`define TSW_FLG_WIN 2
`define TSW_FLG_OVF 3
`define TSW_SYNC_SRST 0
`define TSW_SYNC_EN 1
`define TSW_RST_FIELD 24'h000000
`define TSW_SYNC_CYCLES 3
`define TSW_RESP_OKAY 2'b00
`define TSW_RESP_SLVERR 2'b10
`endif

// ==== tsw_pkg.sv ====
// types shared by the sensor result block modules
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package tsw_pkg;
  typedef logic [23:0] tsw_word_t;
  typedef enum logic [1:0] {
    TSW_WR_IDLE = 2'b01,
    TSW_WR_RESP = 2'b10
  } tsw_wr_state_t;
  typedef struct packed {
    logic busy;
    logic [3:0] cnt;
    logic done;
  } tsw_sync_st_t;
  typedef struct packed {
    tsw_word_t cnt;
    logic done;
    logic ovf;
    tsw_word_t data;
  } tsw_meas_st_t;
  typedef struct packed {
    tsw_wr_state_t wst;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic en;
    logic en_want;
    logic en_go;
    logic srst_go;
    logic winen;
    tsw_word_t lo;
    tsw_word_t hi;
    tsw_word_t gain;
    tsw_word_t result;
    logic rdy;
    logic win;
    logic ovf;
    logic win_pend;
  } tsw_top_st_t;
endpackage
`default_nettype wire

// ==== tsw_meas_if.sv ====
// carrier between the register block and the measurement sequencer
// assumes both ends run on the same clock
`default_nettype none
interface tsw_meas_if;
  import tsw_pkg::*;
  logic en;
  logic clr;
  tsw_word_t gain;
  logic tick;
  logic [31:0] sample;
  logic done;
  logic ovf;
  tsw_word_t data;
  modport ctl (output en, output clr, output gain, output tick, output sample,
               input done, input ovf, input data);
  modport core (input en, input clr, input gain, input tick, input sample,
                output done, output ovf, output data);
endinterface
`default_nettype wire

// ==== tsw_sync.sv ====
// busy tracker for a control bit crossing into the sensor logic
// assumes start is a one-cycle pulse taken only while busy is low
`default_nettype none
`include "tsw_cfg.svh"
module tsw_sync #(
  parameter int SYNC_LEN = `TSW_SYNC_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic start,
  output logic busy,
  output logic done
);
  import tsw_pkg::*;

  if (SYNC_LEN < 1 || SYNC_LEN > 15) begin : g_chk
    $error("tsw_sync: SYNC_LEN must lie in 1..15");
  end

  localparam logic [3:0] LAST = 4'(SYNC_LEN - 1);
  tsw_sync_st_t s_r;
  tsw_sync_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (start && !s_r.busy) begin
      s_nxt.busy = 1'b1;
      s_nxt.cnt = 4'h0;
    end else if (s_r.busy) begin
      if (s_r.cnt == LAST) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign busy = s_r.busy;
  assign done = s_r.done;

  a_busy_rise: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && start && !busy |=> busy)
    else $error("sync busy did not rise after start");
  a_busy_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && busy && s_r.cnt == LAST |=> !busy && done)
    else $error("sync busy did not end at the last count");
endmodule
`default_nettype wire

// ==== tsw_meas.sv ====
// measurement sequencer: counts sensor periods and checks the raw width
// assumes tick is a one-cycle pulse per sensor clock period, synchronous to aclk
`default_nettype none
`include "tsw_cfg.svh"
module tsw_meas (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  tsw_meas_if.core m
);
  import tsw_pkg::*;

  tsw_meas_st_t s_r;
  tsw_meas_st_t s_nxt;

  function automatic logic too_wide(input logic [31:0] v);
    return !((&v[31:23]) || !(|v[31:23]));
  endfunction

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (m.clr || !m.en) begin
      s_nxt.cnt = `TSW_RST_FIELD;
    end else if (m.tick && m.gain != `TSW_RST_FIELD) begin
      if (s_r.cnt == m.gain - 24'h000001) begin
        s_nxt.cnt = `TSW_RST_FIELD;
        s_nxt.done = 1'b1;
        s_nxt.ovf = too_wide(m.sample);
        s_nxt.data = m.sample[23:0];
      end else begin
        s_nxt.cnt = s_r.cnt + 24'h000001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign m.done = s_r.done;
  assign m.ovf = s_r.ovf;
  assign m.data = s_r.data;

  a_gain_period: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && m.en && !m.clr && m.tick && m.gain != 24'h000000 && s_r.cnt == m.gain - 24'h000001
    |=> m.done && s_r.cnt == 24'h000000)
    else $error("measurement did not end after gain periods");
  a_wide_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    m.done |-> m.ovf == too_wide($past(m.sample)))
    else $error("overflow does not match the sample width");
endmodule
`default_nettype wire

// ==== tsw_top.sv ====
// sensor result and window register block with an AXI4-Lite slave port
// assumes one clock; sensor tick and sample are synchronous inputs from the analog core
//
// Our own choice: register access over AXI4-Lite.
`default_nettype none
`include "tsw_cfg.svh"
module tsw_top #(
  parameter int SYNC_LEN = `TSW_SYNC_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic sensor_tick,
  input wire logic [31:0] sensor_sample,
  input wire logic write_protect,
  output tsw_pkg::tsw_word_t result_out,
  output logic sensor_enable
);
  import tsw_pkg::*;

  localparam tsw_top_st_t TOP_RST = '{wst: TSW_WR_IDLE, awready: 1'b1, wready: 1'b1,
                                     arready: 1'b1, default: '0};

  tsw_top_st_t s_r;
  tsw_top_st_t s_nxt;
  tsw_meas_if mif();
  logic en_busy;
  logic en_done;
  logic srst_busy;
  logic srst_done;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic wr_go;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic field_lock;
  logic ctrl_lock;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = val[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] word_ofs(input logic [7:0] a);
    return {a[7:2], 2'b00};
  endfunction

  function automatic logic in_window(input tsw_word_t v, input tsw_word_t lo,
                                     input tsw_word_t hi);
    return $signed(v) >= $signed(lo) && $signed(v) <= $signed(hi);
  endfunction

  tsw_sync #(.SYNC_LEN(SYNC_LEN)) u_en_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .start(s_r.en_go),
    .busy(en_busy),
    .done(en_done)
  );

  tsw_sync #(.SYNC_LEN(SYNC_LEN)) u_srst_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .start(s_r.srst_go),
    .busy(srst_busy),
    .done(srst_done)
  );

  tsw_meas u_meas (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .m(mif.core)
  );

  // sequencer halts while a soft reset is pending so no stale result lands after it
  assign mif.en = s_r.en && !srst_busy;
  assign mif.clr = srst_busy || s_r.srst_go;
  assign mif.gain = s_r.gain;
  assign mif.tick = sensor_tick;
  assign mif.sample = sensor_sample;

  assign aw_fire = s_axi_awvalid && s_r.awready;
  assign w_fire = s_axi_wvalid && s_r.wready;
  assign ar_fire = s_axi_arvalid && s_r.arready;
  assign wr_go = s_r.wst == TSW_WR_IDLE && (s_r.aw_got || aw_fire) && (s_r.w_got || w_fire);
  assign wr_addr = s_r.aw_got ? s_r.awaddr : s_axi_awaddr;
  assign wr_data = s_r.w_got ? s_r.wdata : s_axi_wdata;
  assign wr_strb = s_r.w_got ? s_r.wstrb : s_axi_wstrb;
  assign field_lock = write_protect || s_r.en || en_busy || s_r.en_go;
  assign ctrl_lock = write_protect || en_busy || s_r.en_go || srst_busy || s_r.srst_go;

  always_comb begin
    logic [31:0] ctl_word;
    logic [31:0] rd_word;
    logic rd_hit;
    logic wr_hit;
    ctl_word = 32'h00000000;
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    wr_hit = 1'b1;
    s_nxt = s_r;
    s_nxt.en_go = 1'b0;
    s_nxt.srst_go = 1'b0;
    s_nxt.win_pend = 1'b0;
    if (aw_fire) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (w_fire) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    case (s_r.wst)
      TSW_WR_IDLE: begin
        if (wr_go) begin
          s_nxt.aw_got = 1'b0;
          s_nxt.w_got = 1'b0;
          s_nxt.bvalid = 1'b1;
          s_nxt.wst = TSW_WR_RESP;
          ctl_word[`TSW_CTRL_EN] = s_r.en_want;
          ctl_word[`TSW_CTRL_WINEN] = s_r.winen;
          ctl_word = merge(ctl_word, wr_data, wr_strb);
          case (word_ofs(wr_addr))
            `TSW_OFS_CTRL: begin
              if (!ctrl_lock) begin
                s_nxt.winen = ctl_word[`TSW_CTRL_WINEN];
                if (ctl_word[`TSW_CTRL_EN] != s_r.en_want) begin
                  s_nxt.en_want = ctl_word[`TSW_CTRL_EN];
                  s_nxt.en_go = 1'b1;
                end
                if (ctl_word[`TSW_CTRL_SRST]) begin
                  s_nxt.srst_go = 1'b1;
                end
              end
            end
            `TSW_OFS_FLAGS: begin
              if (wr_strb[0] && wr_data[`TSW_FLG_RDY]) begin
                s_nxt.rdy = 1'b0;
              end
              if (wr_strb[0] && wr_data[`TSW_FLG_WIN]) begin
                s_nxt.win = 1'b0;
              end
              if (wr_strb[0] && wr_data[`TSW_FLG_OVF]) begin
                s_nxt.ovf = 1'b0;
              end
            end
            `TSW_OFS_SYNC, `TSW_OFS_RESULT: begin
            end
            `TSW_OFS_WINLO: begin
              if (!field_lock) begin
                s_nxt.lo = 24'(merge({8'h00, s_r.lo}, wr_data, wr_strb));
              end
            end
            `TSW_OFS_WINHI: begin
              if (!field_lock) begin
                s_nxt.hi = 24'(merge({8'h00, s_r.hi}, wr_data, wr_strb));
              end
            end
            `TSW_OFS_GAIN: begin
              if (!field_lock) begin
                s_nxt.gain = 24'(merge({8'h00, s_r.gain}, wr_data, wr_strb));
              end
            end
            default: begin
              wr_hit = 1'b0;
            end
          endcase
          s_nxt.bresp = wr_hit ? `TSW_RESP_OKAY : `TSW_RESP_SLVERR;
        end
      end
      TSW_WR_RESP: begin
        if (s_axi_bready) begin
          s_nxt.bvalid = 1'b0;
          s_nxt.wst = TSW_WR_IDLE;
        end
      end
      default: begin
        s_nxt.wst = TSW_WR_IDLE;
      end
    endcase
    s_nxt.awready = s_nxt.wst == TSW_WR_IDLE && !s_nxt.aw_got;
    s_nxt.wready = s_nxt.wst == TSW_WR_IDLE && !s_nxt.w_got;

    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (ar_fire) begin
      case (word_ofs(s_axi_araddr))
        `TSW_OFS_CTRL: begin
          rd_word[`TSW_CTRL_SRST] = srst_busy || s_r.srst_go;
          rd_word[`TSW_CTRL_EN] = s_r.en_want;
          rd_word[`TSW_CTRL_WINEN] = s_r.winen;
        end
        `TSW_OFS_FLAGS: begin
          rd_word[`TSW_FLG_RDY] = s_r.rdy;
          rd_word[`TSW_FLG_WIN] = s_r.win;
          rd_word[`TSW_FLG_OVF] = s_r.ovf;
        end
        `TSW_OFS_SYNC: begin
          rd_word[`TSW_SYNC_EN] = en_busy || s_r.en_go;
          rd_word[`TSW_SYNC_SRST] = srst_busy || s_r.srst_go;
        end
        `TSW_OFS_RESULT: begin
          rd_word = {8'h00, s_r.result};
          s_nxt.rdy = 1'b0;
          s_nxt.win = 1'b0;
        end
        `TSW_OFS_WINLO: rd_word = {8'h00, s_r.lo};
        `TSW_OFS_WINHI: rd_word = {8'h00, s_r.hi};
        `TSW_OFS_GAIN: rd_word = {8'h00, s_r.gain};
        default: rd_hit = 1'b0;
      endcase
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd_word;
      s_nxt.rresp = rd_hit ? `TSW_RESP_OKAY : `TSW_RESP_SLVERR;
    end
    s_nxt.arready = !s_nxt.rvalid;

    if (en_done) begin
      s_nxt.en = s_r.en_want;
    end
    if (srst_done) begin
      s_nxt.en = 1'b0;
      s_nxt.en_want = 1'b0;
      s_nxt.winen = 1'b0;
      s_nxt.lo = `TSW_RST_FIELD;
      s_nxt.hi = `TSW_RST_FIELD;
      s_nxt.result = `TSW_RST_FIELD;
      s_nxt.rdy = 1'b0;
      s_nxt.win = 1'b0;
      s_nxt.ovf = 1'b0;
    end else if (mif.done) begin
      // overflow leaves ready unchanged; a win set beats write-one and read clears, soft reset beats it
      if (mif.ovf) begin
        s_nxt.ovf = 1'b1;
      end else begin
        s_nxt.result = mif.data;
        s_nxt.rdy = 1'b1;
        s_nxt.win_pend = s_r.winen && in_window(mif.data, s_r.lo, s_r.hi);
      end
    end
    if (s_r.win_pend && !srst_done) begin
      s_nxt.win = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= TOP_RST;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign result_out = s_r.result;
  assign sensor_enable = s_r.en;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_en_applied: assert property (ce && en_done |=> s_r.en == $past(s_r.en_want))
    else $error("enable not applied when its sync ended");
  a_en_busy_seen: assert property (ce && s_r.en_go |=> en_busy)
    else $error("enable busy missing after control write");
  a_srst_busy_seen: assert property (ce && s_r.srst_go |=> srst_busy)
    else $error("soft reset busy missing after request");
  a_result_load: assert property (ce && mif.done && !mif.ovf && !srst_done
    |=> s_r.rdy && s_r.result == $past(mif.data))
    else $error("result or ready not loaded from measurement");
  a_lo_locked: assert property (ce && wr_go && field_lock && !srst_done
    && word_ofs(wr_addr) == `TSW_OFS_WINLO |=> $stable(s_r.lo))
    else $error("lower threshold changed while locked");
  a_hi_locked: assert property (ce && wr_go && field_lock && !srst_done
    && word_ofs(wr_addr) == `TSW_OFS_WINHI |=> $stable(s_r.hi))
    else $error("upper threshold changed while locked");
  a_gain_kept: assert property (ce && srst_done && !(wr_go && !field_lock)
    |=> $stable(s_r.gain))
    else $error("gain lost on soft reset");
  a_win_delay: assert property (ce && mif.done && !mif.ovf && !srst_done && s_r.winen
    && in_window(mif.data, s_r.lo, s_r.hi) ##1 ce && !srst_done |=> s_r.win)
    else $error("window flag not set one cycle after match");
  a_ovf_no_rdy: assert property (ce && mif.done && mif.ovf && !srst_done && !s_r.rdy
    && !(s_r.win_pend) |=> s_r.ovf && !s_r.rdy)
    else $error("overflow handling wrong");
  a_read_clears: assert property (ce && ar_fire && word_ofs(s_axi_araddr) == `TSW_OFS_RESULT
    && !mif.done |=> !s_r.rdy)
    else $error("result read did not clear ready");
  a_win_signed: assert property (ce && mif.done && !mif.ovf
    && $signed(mif.data) < $signed(s_r.lo) |=> !s_r.win_pend)
    else $error("window matched below the lower threshold");
  a_bvalid_hold: assert property (ce && s_r.bvalid && !s_axi_bready |=> s_r.bvalid)
    else $error("write response dropped before bready");

  c_result: cover property (ce && mif.done && !mif.ovf ##[1:20] ar_fire);
  c_window: cover property (s_r.win_pend ##1 s_r.win);
  c_overflow: cover property (ce && mif.done && mif.ovf);
  c_soft_reset: cover property (s_r.srst_go ##[1:20] srst_done);
endmodule
`default_nettype wire

// ==== tb_tsw_top.sv ====
// self-checking bench for the sensor result and window register block
// assumes the design files compile before this one; drives the AXI4-Lite port directly
`default_nettype none
module tb_tsw_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tsw_pkg::*;
  // longer than the default so a read right after the write still sees busy
  localparam int SYNC_N = 8;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic sensor_tick = 1'b0;
  logic [31:0] sensor_sample = 32'h0;
  logic write_protect = 1'b0;
  tsw_word_t result_out;
  logic sensor_enable;
  logic [1:0] wresp, rresp;
  logic [31:0] d;
  int n_errors = 0;
  int num_checks = 0;

  tsw_top #(.SYNC_LEN(SYNC_N)) dut_u (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .sensor_tick, .sensor_sample, .write_protect,
    .result_out, .sensor_enable);

  initial begin
    forever #25 aclk = ~aclk;
  end

  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask

  // handshakes are judged at the falling edge, where ready and valid are settled
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int i;
    logic ad, wd, g;
    ad = 1'b0;
    wd = 1'b0;
    g = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50 && !(ad && wd); i++) begin
      @(negedge aclk);
      if (s_axi_awready) ad = 1'b1;
      if (s_axi_wready) wd = 1'b1;
      @(posedge aclk);
      if (ad) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
    end
    for (i = 0; i < 50 && !g; i++) begin
      @(negedge aclk);
      g = s_axi_bvalid;
      wresp = s_axi_bresp;
      @(posedge aclk);
    end
    s_axi_bready <= 1'b0;
    if (!g) begin
      n_errors++;
      complete_run();
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    int i;
    logic ad, g;
    ad = 1'b0;
    g = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50 && !ad; i++) begin
      @(negedge aclk);
      ad = s_axi_arready;
      @(posedge aclk);
      if (ad) s_axi_arvalid <= 1'b0;
    end
    for (i = 0; i < 50 && !g; i++) begin
      @(negedge aclk);
      g = s_axi_rvalid;
      v = s_axi_rdata;
      rresp = s_axi_rresp;
      @(posedge aclk);
    end
    s_axi_rready <= 1'b0;
    if (!g) begin
      n_errors++;
      complete_run();
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string what);
    logic [31:0] v;
    rd(a, v);
    chk(what, e, v);
  endtask

  // waits until the masked sync busy bits read zero
  task automatic poll(input logic [31:0] m);
    int i;
    logic [31:0] v;
    v = m;
    for (i = 0; i < 60 && (v & m) != 0; i++) rd(8'h08, v);
    chk("sync_idle", 32'h0, v & m);
    if ((v & m) != 0) begin
      complete_run();
    end
  endtask

  task automatic ticks(input int n, input logic [31:0] s);
    repeat (n) begin
      @(posedge aclk);
      sensor_tick <= 1'b1;
      sensor_sample <= s;
      @(posedge aclk);
      sensor_tick <= 1'b0;
    end
    repeat (3) @(posedge aclk);
  endtask

  task automatic t_reset_vals;
    rc(8'h08, 32'h0, "sync_reset");
    rc(8'h0C, 32'h0, "result_reset");
    rc(8'h10, 32'h0, "lower_reset");
    rc(8'h14, 32'h0, "upper_reset");
    rc(8'h18, 32'h0, "gain_reset");
    chk("result_out_reset", 32'h0, {8'h00, result_out});
  endtask

  task automatic t_rw;
    wr(8'h10, 32'hFFFFFFFF);
    rc(8'h10, 32'h00FFFFFF, "lower_rw");
    wr(8'h14, 32'h12345678);
    rc(8'h14, 32'h00345678, "upper_rw");
    wr(8'h18, 32'hA5A5A5A5);
    rc(8'h18, 32'h00A5A5A5, "gain_rw");
    s_axi_wstrb <= 4'h1;
    wr(8'h18, 32'h00000000);
    s_axi_wstrb <= 4'hF;
    rc(8'h18, 32'h00A5A500, "gain_strobe");
    wr(8'h0C, 32'hFFFFFFFF);
    rc(8'h0C, 32'h0, "result_ro");
    rc(8'h40, 32'h0, "unmapped_data");
    chk("unmapped_resp", 32'h2, {30'h0, rresp});
  endtask

  task automatic t_protect;
    write_protect <= 1'b1;
    wr(8'h10, 32'h0);
    chk("locked_resp", 32'h0, {30'h0, wresp});
    rc(8'h10, 32'h00FFFFFF, "lower_wp");
    wr(8'h14, 32'h0);
    rc(8'h14, 32'h00345678, "upper_wp");
    wr(8'h18, 32'h0);
    rc(8'h18, 32'h00A5A500, "gain_wp");
    write_protect <= 1'b0;
  endtask

  task automatic t_enable;
    wr(8'h10, 32'h00FFFFF6);
    wr(8'h14, 32'h00000064);
    wr(8'h18, 32'h00000003);
    wr(8'h00, 32'h00000006);
    rc(8'h08, 32'h2, "enable_busy");
    poll(32'h3);
    chk("sensor_enable_on", 32'h1, {31'h0, sensor_enable});
    wr(8'h18, 32'h7);
    rc(8'h18, 32'h3, "gain_enlock");
    wr(8'h14, 32'h0);
    rc(8'h14, 32'h64, "upper_enlock");
  endtask

  task automatic t_measure;
    ticks(2, 32'hFFFFFFFB);
    rc(8'h04, 32'h0, "flags_early");
    ticks(1, 32'hFFFFFFFB);
    rc(8'h04, 32'h5, "flags_inside");
    rc(8'h0C, 32'h00FFFFFB, "result_neg");
    chk("result_out", 32'h00FFFFFB, {8'h00, result_out});
    rc(8'h04, 32'h0, "flags_after_read");
    ticks(3, 32'h00000064);
    rc(8'h04, 32'h5, "flags_upper_edge");
    wr(8'h04, 32'h4);
    rc(8'h04, 32'h1, "win_w1c");
    wr(8'h04, 32'h1);
    ticks(3, 32'h000000C8);
    rc(8'h04, 32'h1, "flags_outside");
    wr(8'h04, 32'h1);
    rc(8'h04, 32'h0, "rdy_w1c");
    ticks(3, 32'hFFFFFFF0);
    rc(8'h04, 32'h1, "flags_below");
    wr(8'h04, 32'h1);
    ticks(3, 32'h01000000);
    rc(8'h04, 32'h8, "flags_ovf");
    wr(8'h04, 32'h8);
    rc(8'h04, 32'h0, "ovf_w1c");
  endtask

  task automatic t_soft_reset;
    logic [31:0] v;
    wr(8'h00, 32'h1);
    rd(8'h08, v);
    chk("srst_busy", 32'h1, v & 32'h1);
    poll(32'h3);
    rc(8'h18, 32'h3, "gain_kept");
    rc(8'h10, 32'h0, "lower_cleared");
    rc(8'h0C, 32'h0, "result_cleared");
    chk("sensor_enable_off", 32'h0, {31'h0, sensor_enable});
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc(8'h18, 32'h0, "gain_hard_reset");
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_vals();
    t_rw();
    t_protect();
    t_enable();
    t_measure();
    t_soft_reset();
    complete_run();
  end
endmodule
`default_nettype wire
